//--- sensor_config_and_shutter_control.sv
// configuration upload, output options, roi pointers and global shutter
//
// Behaviour
// - dual enable runs both amplifier paths, else muxes to output one
// - standby bit low puts whole output amplifier in standby
// - coarse offset field sets black reference, all ones highest
// - drive bit low tristates the pixel code outputs
// - linear bit one gives linear transfer, zero a compressive law
// - polarity zero inverts every bit of the conversion result
// - port select one picks parallel, else serial select picks serial
// - parallel strobe latches word: bits 15:12 index, 11:0 value
// - serial load strobe moves shifted word into register, same split
// - frame begin loads row start, line advance loads column start
// - sequencer suspended while exposure begin or end is asserted
// - integration timer reaches length, elapsed high one granulated period
// - four granulated periods of reset; counting starts after begin falls
// - two granulated periods make the array readable after exposure end
`timescale 1ns/1ps
`default_nettype none
module sensor_config_and_shutter_control (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // interface selection straps
    input wire logic port_select,
    input wire logic serial_select,
    // parallel configuration port
    input wire sensor_cfg_pkg::cfg_word_s parallel_word,
    input wire logic parallel_write_strobe,
    // serial configuration port
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_load_strobe,
    // sequencer strobes
    input wire sensor_cfg_pkg::strobes_s strobes,
    // converter raw sample
    input wire logic [9:0] raw_sample,
    // amplifier controls
    output logic path_two_active,
    output logic mux_to_output_one,
    output logic amplifier_active,
    output logic [6:0] coarse_offset_level,
    output logic [6:0] fine_offset_trim,
    // pixel code pins
    output logic [9:0] pixel_code_out,
    output logic [9:0] pixel_code_oe,
    // readout pointers and shutter status
    output logic [10:0] row_pointer,
    output logic [10:0] column_pointer,
    output logic exposure_elapsed,
    output logic array_readable
);
    import sensor_cfg_pkg::*;

    // ========================================================
    // configuration upload
    logic par_q_r, ser_q_r, sclk_q_r;
    logic [15:0] shift_word;
    logic par_write, ser_write, cfg_write;
    cfg_word_s cfg_word;
    logic [6:0] amp_r, amp_nxt, coarse_r, coarse_nxt, fine_r, fine_nxt;
    logic [2:0] conv_r, conv_nxt;
    logic [11:0] exp_len_r, exp_len_nxt;
    logic [10:0] col_start_r, col_start_nxt, row_start_r, row_start_nxt;
    logic [1:0] gran_r, gran_nxt;

    function automatic logic write_to(input cfg_word_s w,
                                      input logic [3:0] idx);
        write_to = (w.index == idx);
    endfunction : write_to

    serial_word_shifter u_shift (
        .clk(clk),
        .rst_n(rst_n),
        .shift_en(serial_clock && !sclk_q_r && !port_select),
        .bit_in(serial_data),
        .word_r(shift_word)
    );

    // strobe edges so a strobe held for many cycles writes once
    always_comb begin
        par_write = parallel_write_strobe && !par_q_r && port_select;
        ser_write = serial_load_strobe && !ser_q_r && !port_select
                    && serial_select;
        cfg_word = par_write ? parallel_word
                             : cfg_word_s'(shift_word);
        cfg_write = par_write || ser_write;
        amp_nxt = amp_r;
        coarse_nxt = coarse_r;
        fine_nxt = fine_r;
        conv_nxt = conv_r;
        exp_len_nxt = exp_len_r;
        col_start_nxt = col_start_r;
        row_start_nxt = row_start_r;
        gran_nxt = gran_r;
        if (cfg_write) begin
            if (write_to(cfg_word, IDX_AMPLIFIER))
                amp_nxt = cfg_word.value[6:0];
            if (write_to(cfg_word, IDX_COARSE))
                coarse_nxt = cfg_word.value[6:0];
            if (write_to(cfg_word, IDX_FINE)) fine_nxt = cfg_word.value[6:0];
            if (write_to(cfg_word, IDX_CONVERTER))
                conv_nxt = cfg_word.value[2:0];
            if (write_to(cfg_word, IDX_EXPOSURE)) exp_len_nxt = cfg_word.value;
            if (write_to(cfg_word, IDX_COL_START))
                col_start_nxt = cfg_word.value[10:0];
            if (write_to(cfg_word, IDX_ROW_START))
                row_start_nxt = cfg_word.value[10:0];
            if (write_to(cfg_word, IDX_GRANULARITY))
                gran_nxt = cfg_word.value[1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            par_q_r <= 1'b0;
            ser_q_r <= 1'b0;
            sclk_q_r <= 1'b0;
            amp_r <= AMP_RST;
            coarse_r <= COARSE_RST;
            fine_r <= FINE_RST;
            conv_r <= CONV_RST;
            exp_len_r <= EXPOSURE_RST;
            col_start_r <= START_RST;
            row_start_r <= START_RST;
            gran_r <= GRAN_RST;
        end else begin
            par_q_r <= parallel_write_strobe;
            ser_q_r <= serial_load_strobe;
            sclk_q_r <= serial_clock;
            amp_r <= amp_nxt;
            coarse_r <= coarse_nxt;
            fine_r <= fine_nxt;
            conv_r <= conv_nxt;
            exp_len_r <= exp_len_nxt;
            col_start_r <= col_start_nxt;
            row_start_r <= row_start_nxt;
            gran_r <= gran_nxt;
        end
    end

    // ========================================================
    // output amplifier and converter options
    // compressive law: steep in the dark, flat in the bright
    function automatic logic [9:0] transfer(input logic [9:0] x,
                                            input logic linear);
        if (linear) transfer = x;
        else if (x < 10'h080) transfer = {x[7:0], 2'b00};
        else if (x < 10'h180) transfer = 10'h200 + (x - 10'h080);
        else transfer = 10'h300 + ((x - 10'h180) >> 2);
    endfunction : transfer

    logic [9:0] code_nxt;

    always_comb begin
        code_nxt = transfer(raw_sample, conv_r[LINEAR_BIT]);
        if (!conv_r[POLARITY_BIT]) code_nxt = ~code_nxt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            path_two_active <= 1'b0;
            mux_to_output_one <= 1'b1;
            amplifier_active <= 1'b0;
            coarse_offset_level <= COARSE_RST;
            fine_offset_trim <= FINE_RST;
            pixel_code_out <= 10'h000;
            pixel_code_oe <= 10'h000;
        end else begin
            path_two_active <= amp_r[DUAL_OUT_BIT]
                               && amp_r[STANDBY_N_BIT];
            mux_to_output_one <= !amp_r[DUAL_OUT_BIT];
            amplifier_active <= amp_r[STANDBY_N_BIT];
            coarse_offset_level <= coarse_r;
            fine_offset_trim <= fine_r;
            pixel_code_out <= code_nxt;
            pixel_code_oe <= {10{conv_r[DRIVE_BIT]}};
        end
    end

    // ========================================================
    // region of interest pointers
    logic [10:0] row_nxt, col_nxt;

    always_comb begin
        row_nxt = row_pointer;
        col_nxt = column_pointer;
        if (strobes.frame_begin) row_nxt = row_start_r;
        else if (strobes.line_advance) row_nxt = row_pointer + 11'h001;
        if (strobes.line_advance || strobes.column_pointer_load)
            col_nxt = col_start_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            row_pointer <= START_RST;
            column_pointer <= START_RST;
        end else begin
            row_pointer <= row_nxt;
            column_pointer <= col_nxt;
        end
    end

    // ========================================================
    // global shutter sequencer
    shutter_state_e state_r, state_nxt;
    logic [7:0] gran_cnt_r, gran_cnt_nxt, gran_max;
    logic [2:0] phase_r, phase_nxt;
    logic [11:0] int_cnt_r, int_cnt_nxt;
    logic elapsed_nxt, readable_nxt, tick, held;

    always_comb begin
        gran_max = 8'(({8'h01} << (GRAN_BASE_LOG2 + int'(gran_r))) - 1);
        tick = (gran_cnt_r == gran_max);
        held = strobes.exposure_begin || strobes.exposure_end;
        state_nxt = state_r;
        gran_cnt_nxt = tick ? 8'h00 : gran_cnt_r + 8'h01;
        phase_nxt = phase_r;
        int_cnt_nxt = int_cnt_r;
        elapsed_nxt = exposure_elapsed;
        readable_nxt = array_readable;
        if (held) gran_cnt_nxt = 8'h00;
        if (tick && !held) elapsed_nxt = 1'b0;
        if (strobes.exposure_begin) begin
            state_nxt = SH_HOLD_BEGIN;
            readable_nxt = 1'b0;
            elapsed_nxt = 1'b0;
        end else begin
            unique case (state_r)
                SH_IDLE: ;
                SH_HOLD_BEGIN: begin
                    state_nxt = SH_ARRAY_RESET;
                    phase_nxt = 3'h0;
                    int_cnt_nxt = 12'h000;
                    gran_cnt_nxt = 8'h00;
                end
                SH_ARRAY_RESET, SH_INTEGRATE: begin
                    if (strobes.exposure_end) begin
                        state_nxt = SH_HOLD_END;
                    end else if (tick) begin
                        if (int_cnt_r != exp_len_r) begin
                            int_cnt_nxt = int_cnt_r + 12'h001;
                            if (int_cnt_r + 12'h001 == exp_len_r)
                                elapsed_nxt = 1'b1;
                        end
                        phase_nxt = phase_r + 3'h1;
                        if (state_r == SH_ARRAY_RESET
                            && phase_r == RESET_TICKS - 3'h1)
                            state_nxt = SH_INTEGRATE;
                    end
                end
                SH_HOLD_END: begin
                    if (!strobes.exposure_end) begin
                        state_nxt = SH_SETTLE;
                        phase_nxt = 3'h0;
                        gran_cnt_nxt = 8'h00;
                    end
                end
                SH_SETTLE: begin
                    if (tick) begin
                        phase_nxt = phase_r + 3'h1;
                        if (phase_r == SETTLE_TICKS - 3'h1) begin
                            state_nxt = SH_IDLE;
                            readable_nxt = 1'b1;
                        end
                    end
                end
                default: state_nxt = SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SH_IDLE;
            gran_cnt_r <= 8'h00;
            phase_r <= 3'h0;
            int_cnt_r <= 12'h000;
            exposure_elapsed <= 1'b0;
            array_readable <= 1'b0;
        end else begin
            state_r <= state_nxt;
            gran_cnt_r <= gran_cnt_nxt;
            phase_r <= phase_nxt;
            int_cnt_r <= int_cnt_nxt;
            exposure_elapsed <= elapsed_nxt;
            array_readable <= readable_nxt;
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [8:0] high_cnt_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) high_cnt_r <= 9'h000;
        else if (exposure_elapsed && !held) high_cnt_r <= high_cnt_r + 9'h001;
        else if (!exposure_elapsed) high_cnt_r <= 9'h000;
    end

    sequence par_coarse_write;
        par_write && parallel_word.index == IDX_COARSE;
    endsequence

    AST_PAR_WRITE: assert property (par_coarse_write |-> ##2
        coarse_offset_level == $past(parallel_word.value[6:0], 2))
        else $error("parallel write did not reach coarse offset");
    AST_SER_WRITE: assert property (ser_write
        && shift_word[15:12] == IDX_FINE |-> ##2
        fine_offset_trim == $past(shift_word[6:0], 2))
        else $error("serial load did not reach fine trim");
    // with no parallel write, a deselected serial port must change nothing
    AST_PORT_PRIORITY: assert property ((port_select || !serial_select)
        && !par_write |=> $stable({amp_r, coarse_r, fine_r, conv_r,
        exp_len_r, col_start_r, row_start_r, gran_r}))
        else $error("register written by a deselected port");
    AST_DRIVE: assert property (##1 pixel_code_oe
        == {10{$past(conv_r[DRIVE_BIT])}})
        else $error("pixel drive does not follow drive bit");
    AST_POLARITY: assert property (conv_r[LINEAR_BIT]
        && !conv_r[POLARITY_BIT] && $stable(conv_r)
        |=> pixel_code_out == ~$past(raw_sample))
        else $error("inverted code wrong");
    AST_DUAL: assert property (##1 mux_to_output_one
        == !$past(amp_r[DUAL_OUT_BIT]))
        else $error("output mux does not follow dual enable");
    AST_SUSPEND: assert property (state_r == SH_HOLD_END
        && strobes.exposure_end |=> state_r == SH_HOLD_END
        && $stable(int_cnt_r))
        else $error("sequencer advanced while suspended");
    AST_RESET_FOUR: assert property (state_r == SH_ARRAY_RESET
        && tick && !held && phase_r == 3'h3 |=> state_r == SH_INTEGRATE)
        else $error("array reset phase not four periods");
    AST_SETTLE_TWO: assert property (state_r == SH_SETTLE
        && tick && !held && phase_r == 3'h1 |=> array_readable)
        else $error("array not readable after two periods");
    AST_ELAPSED_ONE: assert property ($fell(exposure_elapsed)
        && !$past(strobes.exposure_begin)
        |-> high_cnt_r == 9'(gran_max) + 9'h001)
        else $error("elapsed pulse not one granulated period");
    AST_ROW_LOAD: assert property (strobes.frame_begin
        |=> row_pointer == $past(row_start_r))
        else $error("row start not loaded on frame begin");
    AST_COL_LOAD: assert property (strobes.line_advance
        |=> column_pointer == $past(col_start_r))
        else $error("column start not loaded on line advance");

endmodule : sensor_config_and_shutter_control
`default_nettype wire

//--- sensor_cfg_pkg.sv
// shared constants and carriers for the sensor configuration and shutter block
package sensor_cfg_pkg;

    // ========================================================
    // configuration word layout
    localparam int WORD_W = 16;
    localparam int INDEX_MSB = 15;
    localparam int INDEX_LSB = 12;
    localparam int VALUE_MSB = 11;
    localparam int VALUE_LSB = 0;

    typedef struct packed {
        logic [3:0] index;
        logic [11:0] value;
    } cfg_word_s;

    // ========================================================
    // register indices
    localparam logic [3:0] IDX_AMPLIFIER = 4'h0;
    localparam logic [3:0] IDX_COARSE = 4'h1;
    localparam logic [3:0] IDX_FINE = 4'h2;
    localparam logic [3:0] IDX_CONVERTER = 4'h3;
    localparam logic [3:0] IDX_EXPOSURE = 4'h4;
    localparam logic [3:0] IDX_COL_START = 4'h5;
    localparam logic [3:0] IDX_ROW_START = 4'h6;
    localparam logic [3:0] IDX_GRANULARITY = 4'h7;

    // ========================================================
    // field positions
    localparam int DUAL_OUT_BIT = 5;
    localparam int STANDBY_N_BIT = 6;
    localparam int DRIVE_BIT = 0;
    localparam int LINEAR_BIT = 1;
    localparam int POLARITY_BIT = 2;

    // ========================================================
    // reset values
    localparam logic [6:0] AMP_RST = 7'h00;
    localparam logic [6:0] COARSE_RST = 7'h00;
    localparam logic [6:0] FINE_RST = 7'h40;
    localparam logic [2:0] CONV_RST = 3'h0;
    localparam logic [11:0] EXPOSURE_RST = 12'h00A;
    localparam logic [10:0] START_RST = 11'h000;
    localparam logic [1:0] GRAN_RST = 2'h0;

    // ========================================================
    // shutter sequencer timing, in granulated periods
    localparam logic [2:0] RESET_TICKS = 3'h4;
    localparam logic [2:0] SETTLE_TICKS = 3'h2;
    localparam int GRAN_BASE_LOG2 = 5;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b000,
        SH_HOLD_BEGIN = 3'b001,
        SH_ARRAY_RESET = 3'b011,
        SH_INTEGRATE = 3'b010,
        SH_HOLD_END = 3'b110,
        SH_SETTLE = 3'b111
    } shutter_state_e;

    typedef struct packed {
        logic exposure_begin;
        logic exposure_end;
        logic line_advance;
        logic frame_begin;
        logic column_pointer_load;
    } strobes_s;

endpackage : sensor_cfg_pkg

//--- serial_word_shifter.sv
// sixteen-bit shift buffer for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // shift request
    input wire logic shift_en,
    input wire logic bit_in,
    // buffered word
    output logic [15:0] word_r
);
    import sensor_cfg_pkg::*;

    logic [15:0] word_nxt;

    // msb first: each new bit enters at the bottom
    always_comb begin
        word_nxt = word_r;
        if (shift_en) begin
            word_nxt = {word_r[14:0], bit_in};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_r <= 16'h0000;
        end else begin
            word_r <= word_nxt;
        end
    end

endmodule : serial_word_shifter
`default_nettype wire

//--- timing_controller_model.sv
// partner model of the external timing controller and serial host
`timescale 1ns/1ps
`default_nettype none
module timing_controller_model (
    // master clock
    input wire logic clk,
    // sequencer strobes
    output var sensor_cfg_pkg::strobes_s strobes,
    // serial configuration port
    output logic serial_clock,
    output logic serial_data,
    output logic serial_load_strobe
);
    import sensor_cfg_pkg::*;
    // 40 cycles a half keeps the bit rate at the 2.5 MHz ceiling
    localparam int HALF = 40;
    initial begin
        strobes = '0;
        serial_clock = 1'b0;
        serial_data = 1'b0;
        serial_load_strobe = 1'b0;
    end
    // ========================================================
    // strobes change on falling edges only, one cycle or more
    task automatic pulse(input strobes_s pat, input int cycles);
        @(negedge clk);
        strobes = pat;
        repeat (cycles) @(negedge clk);
        strobes = '0;
    endtask : pulse
    // ========================================================
    // three-wire upload; a two-wire mode is never tried
    task automatic send_word(input cfg_word_s w);
        @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            serial_data = w[i];
            repeat (HALF) @(negedge clk);
            serial_clock = 1'b1;
            repeat (HALF) @(negedge clk);
            serial_clock = 1'b0;
        end
        // a stale bit must not look like a held line
        serial_data = ~serial_data;
        serial_load_strobe = 1'b1;
        repeat (2) @(negedge clk);
        serial_load_strobe = 1'b0;
        repeat (2) @(negedge clk);
    endtask : send_word
endmodule : timing_controller_model
`default_nettype wire

//--- testbench.sv
// self-checking testbench for the configuration and shutter block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sensor_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic port_select = 1'b1;
    logic serial_select = 1'b0;
    cfg_word_s parallel_word = '0;
    logic parallel_write_strobe = 1'b0;
    logic [9:0] raw_sample = '0;
    strobes_s strobes;
    logic serial_clock, serial_data, serial_load_strobe;
    logic path_two_active, mux_to_output_one, amplifier_active;
    logic [6:0] coarse_offset_level, fine_offset_trim;
    logic [9:0] pixel_code_out, pixel_code_oe;
    logic [10:0] row_pointer, column_pointer;
    logic exposure_elapsed, array_readable;
    int miscompares = 0;
    int check_count = 0;
    int reg_m [8] = '{0, 0, 64, 0, 10, 0, 0, 0};
    int k, p, v;
    localparam strobes_s ST_BEGIN = strobes_s'(5'h10);
    localparam strobes_s ST_END = strobes_s'(5'h08);
    localparam strobes_s ST_LINE = strobes_s'(5'h04);
    localparam strobes_s ST_FRAME = strobes_s'(5'h02);
    localparam strobes_s ST_COL = strobes_s'(5'h01);
    localparam logic [15:0] WORDS [12] = '{16'h0000, 16'h0020,
        16'h0040, 16'h0060, 16'h0FFF, 16'h107F, 16'h1000, 16'h1F85,
        16'h2040, 16'h2013, 16'h9ABC, 16'hF000};
    localparam int RAWS [6] = '{0, 127, 128, 383, 384, 1023};
    localparam logic [1:0] STRAPS [3] = '{2'b01, 2'b00, 2'b11};

    always #2.5 clk = ~clk;

    sensor_config_and_shutter_control sensor_config_and_shutter_control_i (
        .clk(clk), .rst_n(rst_n), .port_select(port_select),
        .serial_select(serial_select), .parallel_word(parallel_word),
        .parallel_write_strobe(parallel_write_strobe),
        .serial_clock(serial_clock), .serial_data(serial_data),
        .serial_load_strobe(serial_load_strobe), .strobes(strobes),
        .raw_sample(raw_sample), .path_two_active(path_two_active),
        .mux_to_output_one(mux_to_output_one),
        .amplifier_active(amplifier_active),
        .coarse_offset_level(coarse_offset_level),
        .fine_offset_trim(fine_offset_trim),
        .pixel_code_out(pixel_code_out), .pixel_code_oe(pixel_code_oe),
        .row_pointer(row_pointer), .column_pointer(column_pointer),
        .exposure_elapsed(exposure_elapsed),
        .array_readable(array_readable));

    timing_controller_model timing_controller_model_i (
        .clk(clk), .strobes(strobes), .serial_clock(serial_clock),
        .serial_data(serial_data), .serial_load_strobe(serial_load_strobe));

    // ========================================================
    // comparison and verdict
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic compare(input string what, input logic [15:0] e,
                           input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, e, g);
        end
    endtask : compare

    task automatic compare_time(input string what, input int e,
                                input int g, input int tol);
        check_count++;
        if (g < e - tol || g > e + tol) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask : compare_time

    // counts falling edges until the chosen flag shows lvl
    task automatic wait_for(input bit pick_ready, input logic lvl);
        k = 0;
        while ((pick_ready ? array_readable : exposure_elapsed) !== lvl) begin
            @(negedge clk);
            k++;
            if (k > 3000) begin
                miscompares++;
                $display("Error wait expected %0b seen timeout", lvl);
                give_verdict();
            end
        end
    endtask : wait_for

    // ========================================================
    // bench model
    function automatic logic [9:0] code_of(input int raw, input int conv);
        int y;
        if ((conv & 2) != 0) y = raw;
        else if (raw < 128) y = raw * 4;
        else if (raw < 384) y = 512 + raw - 128;
        else y = 768 + (raw - 384) / 4;
        if ((conv & 4) == 0) y = ~y;
        return 10'(y);
    endfunction : code_of

    task automatic pwrite(input logic [3:0] idx, input logic [11:0] val);
        @(negedge clk);
        parallel_word = cfg_word_s'({idx, val});
        parallel_write_strobe = 1'b1;
        @(negedge clk);
        parallel_write_strobe = 1'b0;
        parallel_word = cfg_word_s'(~parallel_word);
        repeat (2) @(negedge clk);
        if (port_select && idx < 4'h8) reg_m[idx] = int'(val);
    endtask : pwrite

    task automatic check_outputs();
        logic [11:0] a;
        a = 12'(reg_m[0]);
        compare("path_two", 16'(a[5] & a[6]), 16'(path_two_active));
        compare("mux_one", 16'(!a[5]), 16'(mux_to_output_one));
        compare("amp_on", 16'(a[6]), 16'(amplifier_active));
        compare("coarse", 16'(reg_m[1] & 127),
                16'(coarse_offset_level));
        compare("fine", 16'(reg_m[2] & 127), 16'(fine_offset_trim));
        compare("oe", reg_m[3][0] ? 16'h03FF : 16'h0,
                16'(pixel_code_oe));
    endtask : check_outputs

    task automatic check_code(input int raw);
        raw_sample = 10'(raw);
        @(negedge clk);
        compare("code", 16'(code_of(raw, reg_m[3])),
                16'(pixel_code_out));
    endtask : check_code

    // ========================================================
    // main sequence
    initial begin
        void'($urandom(32'h5DDD));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        check_outputs();
        compare("row", 16'h0, 16'(row_pointer));
        compare("ready", 16'h0, 16'(array_readable));
        for (int i = 0; i < 18; i++) begin
            // random words stay on the option registers only
            v = (i < 12) ? WORDS[i]
                : ($urandom_range(3) << 12) | ($urandom & 32'hFFF);
            pwrite(v[15:12], v[11:0]);
            check_outputs();
        end
        for (int c = 0; c < 8; c++) begin
            pwrite(IDX_CONVERTER, 12'(c));
            check_outputs();
            foreach (RAWS[i]) check_code(RAWS[i]);
            check_code($urandom_range(1023));
        end
        port_select = 1'b0;
        pwrite(IDX_COARSE, 12'h055);
        check_outputs();
        foreach (STRAPS[i]) begin
            {port_select, serial_select} = STRAPS[i];
            v = $urandom_range(127);
            timing_controller_model_i.send_word({IDX_COARSE, 12'(v)});
            if (STRAPS[i] == 2'b01) reg_m[1] = v;
            check_outputs();
        end
        port_select = 1'b1;
        pwrite(IDX_ROW_START, 12'($urandom_range(1022)));
        pwrite(IDX_COL_START, 12'($urandom_range(319) * 2));
        timing_controller_model_i.pulse(ST_FRAME, 1);
        compare("row", 16'(reg_m[6]), 16'(row_pointer));
        timing_controller_model_i.pulse(ST_LINE, 1);
        compare("row", 16'(reg_m[6] + 1), 16'(row_pointer));
        compare("col", 16'(reg_m[5]), 16'(column_pointer));
        pwrite(IDX_COL_START, 12'h27E);
        timing_controller_model_i.pulse(ST_COL, 1);
        compare("col", 16'h027E, 16'(column_pointer));
        for (int g = 0; g < 4; g++) begin
            pwrite(IDX_GRANULARITY, 12'(g));
            pwrite(IDX_EXPOSURE, 12'd10);
            p = 32 << g;
            timing_controller_model_i.pulse(ST_BEGIN, 8);
            compare("ready", 16'h0, 16'(array_readable));
            wait_for(1'b0, 1'b1);
            compare_time("elapsed_at", 10 * p, k, 3);
            wait_for(1'b0, 1'b0);
            compare_time("elapsed_len", p, k, 0);
            // end is derived from elapsed, never tied to it
            repeat (5) @(negedge clk);
            timing_controller_model_i.pulse(ST_END, 8);
            wait_for(1'b1, 1'b1);
            compare_time("ready_at", 2 * p, k, 3);
        end
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
